/* File: plim_evt_if.sv */
`timescale 1ns/1ns
`default_nettype none

// one-cycle alarm edges from the pin synchroniser to the register bank
interface plim_evt_if #(
  parameter int N = 4
);
  logic [N-1:0] rise;
  modport src (output rise);
  modport dst (input rise);
endinterface

`default_nettype wire

/* File: plim_evt_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module plim_evt_sync #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous alarm pins
  input wire logic [N-1:0] pins,
  // edge pulses
  plim_evt_if.src evt
);

  // ==========================================================
  // two-stage synchroniser, then an edge stage
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] last_q;
  logic [N-1:0] rise_q;
  logic [N-1:0] rise_d;

  // only the sync stage and its delayed copy feed the edge test
  assign rise_d = sync_q & ~last_q;
  assign evt.rise = rise_q;

  // capture chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
      rise_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_q <= rise_d;
    end
  end

endmodule

`default_nettype wire

/* File: plim_pkg.sv */
// How it works
// - pull-in limit is ten bits: high register bits 1:0 over low byte
// - high register keeps limit bits 9:8 in 1:0; 7:2 unused; resets 0
// - mask bit 5 lets secondary differential input interrupt; 0 blocks
// - mask bit 4 lets primary differential input interrupt; 0 blocks
`default_nettype none

package plim_pkg;

  // ==========================================================
  // bus and field widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LIMIT_W = 10;
  localparam int OFFSET_W = 11;
  localparam int NUM_SRC = 4;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_FREQ_LIMIT_LOW = 8'h41;
  localparam logic [7:0] OFF_FREQ_LIMIT_HIGH = 8'h42;
  localparam logic [7:0] OFF_IRQ_MASK_LOW = 8'h43;
  localparam logic [7:0] OFF_IRQ_STATUS_LOW = 8'h4f;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_FREQ_LIMIT_LOW = 8'h76;
  localparam logic [7:0] RST_FREQ_LIMIT_HIGH = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK_LOW = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS_LOW = 8'h00;

  // ==========================================================
  // field layout
  localparam logic [7:0] LIMIT_HIGH_BITS = 8'h03;
  localparam logic [7:0] MASK_BITS = 8'h3c;
  localparam int SRC_LSB = 2;
  localparam int PRI_SE_BIT = 2;
  localparam int SEC_SE_BIT = 3;
  localparam int PRI_DIFF_BIT = 4;
  localparam int SEC_DIFF_BIT = 5;

endpackage

`default_nettype wire

/* File: plim_regs.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module plim_regs
  import plim_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // clock input alarm pins, bit order matches mask bits 2 upward
  input wire logic [NUM_SRC-1:0] SRC_ALARM,
  // tracking offset from the loop, same clock
  input wire logic signed [OFFSET_W-1:0] TRACK_OFFSET,
  // limit and range result
  output logic [LIMIT_W-1:0] PULL_IN_RANGE_LIMIT,
  output logic OFFSET_IN_RANGE,
  // interrupt
  output logic IRQ
);

  // ==========================================================
  // functions
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [OFFSET_W-1:0] magnitude(
    input logic signed [OFFSET_W-1:0] v);
    magnitude = v[OFFSET_W-1] ? OFFSET_W'(-v) : OFFSET_W'(v);
  endfunction

  // ==========================================================
  // storage
  logic [7:0] limit_low_q;
  logic [7:0] limit_low_d;
  logic [7:0] limit_high_q;
  logic [7:0] limit_high_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic in_range_q;
  logic in_range_d;

  // ==========================================================
  // alarm edges
  plim_evt_if #(.N(NUM_SRC)) evt ();

  plim_evt_sync #(
    .N(NUM_SRC)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .pins(SRC_ALARM),
    .evt(evt)
  );

  // ==========================================================
  // address decode
  wire wr_low = WR && hit(ADDR, OFF_FREQ_LIMIT_LOW);
  wire wr_high = WR && hit(ADDR, OFF_FREQ_LIMIT_HIGH);
  wire wr_mask = WR && hit(ADDR, OFF_IRQ_MASK_LOW);
  wire wr_status = WR && hit(ADDR, OFF_IRQ_STATUS_LOW);

  // ==========================================================
  // named mask enables
  wire primary_single_ended_irq_en = mask_q[PRI_SE_BIT];
  wire secondary_single_ended_irq_en = mask_q[SEC_SE_BIT];
  wire primary_diff_input_irq_en = mask_q[PRI_DIFF_BIT];
  wire secondary_diff_input_irq_en = mask_q[SEC_DIFF_BIT];
  wire [NUM_SRC-1:0] src_en = {secondary_diff_input_irq_en,
                               primary_diff_input_irq_en,
                               secondary_single_ended_irq_en,
                               primary_single_ended_irq_en};

  // ==========================================================
  // register next values
  assign limit_low_d = wr_low ? WDATA : limit_low_q;
  assign limit_high_d = wr_high ? (WDATA & LIMIT_HIGH_BITS)
                                : limit_high_q;
  // bits 1:0 and 7:6 are held at zero whatever is written
  assign mask_d = wr_mask ? (WDATA & MASK_BITS) : mask_q;

  // status: write one to clear, a new edge wins over the clear
  wire [7:0] status_set = {2'b00, evt.rise, 2'b00};
  wire [7:0] status_clr = wr_status ? WDATA : 8'h00;
  assign status_d = ((status_q & ~status_clr) | status_set) & MASK_BITS;

  // ==========================================================
  // pull-in limit and symmetric range test
  wire [LIMIT_W-1:0] pull_in_range_limit =
    {limit_high_q[1:0], limit_low_q};
  wire [OFFSET_W-1:0] offset_mag = magnitude(TRACK_OFFSET);
  // same bound on either sign of the offset
  assign in_range_d = (offset_mag <= {1'b0, pull_in_range_limit});

  // ==========================================================
  // interrupt: any unmasked sticky bit
  wire [NUM_SRC-1:0] src_pending = status_q[SRC_LSB +: NUM_SRC] & src_en;
  assign irq_d = |src_pending;

  // ==========================================================
  // read mux, unmapped addresses read zero
  wire [7:0] rd_value =
    hit(ADDR, OFF_FREQ_LIMIT_LOW) ? limit_low_q :
    hit(ADDR, OFF_FREQ_LIMIT_HIGH) ? limit_high_q :
    hit(ADDR, OFF_IRQ_MASK_LOW) ? mask_q :
    hit(ADDR, OFF_IRQ_STATUS_LOW) ? status_q : 8'h00;
  assign rdata_d = RD ? rd_value : 8'h00;

  // ==========================================================
  // configuration registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      limit_low_q <= RST_FREQ_LIMIT_LOW;
      limit_high_q <= RST_FREQ_LIMIT_HIGH;
      mask_q <= RST_IRQ_MASK_LOW;
    end else begin
      limit_low_q <= limit_low_d;
      limit_high_q <= limit_high_d;
      mask_q <= mask_d;
    end
  end

  // status, read data and outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      status_q <= RST_IRQ_STATUS_LOW;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      in_range_q <= 1'b0;
    end else begin
      status_q <= status_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      in_range_q <= in_range_d;
    end
  end

  // ==========================================================
  // outputs
  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign OFFSET_IN_RANGE = in_range_q;
  assign PULL_IN_RANGE_LIMIT = pull_in_range_limit;

  // ==========================================================
  // assertions
  a_limit_low_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (WR && ADDR == OFF_FREQ_LIMIT_LOW)
    |=> PULL_IN_RANGE_LIMIT[7:0] == $past(WDATA))
    else $error("limit low byte not taken from write");

  a_limit_high_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (WR && ADDR == OFF_FREQ_LIMIT_HIGH)
    |=> PULL_IN_RANGE_LIMIT[9:8] == $past(WDATA[1:0]))
    else $error("limit top bits not taken from high register");

  a_high_unused_zero: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (RD && ADDR == OFF_FREQ_LIMIT_HIGH) |=> RDATA[7:2] == 6'h00)
    else $error("unused high register bits read nonzero");

  a_range_both_signs: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    ($stable(TRACK_OFFSET) && $stable(PULL_IN_RANGE_LIMIT)
     && TRACK_OFFSET[OFFSET_W-1]
     && (-TRACK_OFFSET) == {1'b0, PULL_IN_RANGE_LIMIT})
    |=> OFFSET_IN_RANGE)
    else $error("negative offset at limit judged out of range");

  a_range_above: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (!TRACK_OFFSET[OFFSET_W-1]
     && TRACK_OFFSET > $signed({1'b0, PULL_IN_RANGE_LIMIT}))
    |=> !OFFSET_IN_RANGE)
    else $error("offset above limit judged in range");

  a_sec_diff_blocked: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (status_q == 8'h20 && !mask_q[SEC_DIFF_BIT]) |=> !IRQ)
    else $error("masked secondary differential input interrupted");

  a_pri_diff_allowed: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (status_q[PRI_DIFF_BIT] && mask_q[PRI_DIFF_BIT]) |=> IRQ)
    else $error("enabled primary differential input gave no interrupt");

  a_mask_fixed_bits: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (RD && ADDR == OFF_IRQ_MASK_LOW)
    |=> (RDATA[1:0] == 2'b00 && RDATA[7:6] == 2'b00))
    else $error("fixed mask bits read nonzero");

  a_edge_sets_status: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    evt.rise[0] |=> status_q[PRI_SE_BIT])
    else $error("alarm edge did not set status");

  // ==========================================================
  // read data: one cycle after the strobe, zero otherwise
  a_rdata_idle_zero: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");

  a_read_low_value: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (RD && ADDR == OFF_FREQ_LIMIT_LOW) |=> RDATA == $past(limit_low_q))
    else $error("limit low byte read back wrong");

  a_read_mask_value: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (RD && ADDR == OFF_IRQ_MASK_LOW) |=> RDATA == $past(mask_q))
    else $error("mask register read back wrong");

  a_unmapped_read_zero: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (RD && ADDR != OFF_FREQ_LIMIT_LOW && ADDR != OFF_FREQ_LIMIT_HIGH
     && ADDR != OFF_IRQ_MASK_LOW && ADDR != OFF_IRQ_STATUS_LOW)
    |=> RDATA == 8'h00)
    else $error("unmapped address read nonzero");

  // ==========================================================
  // storage: writes land, nothing else moves the registers
  a_high_store_zero: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (WR && ADDR == OFF_FREQ_LIMIT_HIGH) |=> limit_high_q[7:2] == 6'h00)
    else $error("unused high register bits stored");

  a_limit_low_hold: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    !(WR && ADDR == OFF_FREQ_LIMIT_LOW) |=> $stable(limit_low_q))
    else $error("limit low byte changed without a write");

  a_mask_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (WR && ADDR == OFF_IRQ_MASK_LOW)
    |=> (mask_q[5:2] == $past(WDATA[5:2]) && mask_q[1:0] == 2'b00
         && mask_q[7:6] == 2'b00))
    else $error("mask write stored wrong bits");

  a_mask_hold: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    !(WR && ADDR == OFF_IRQ_MASK_LOW) |=> $stable(mask_q))
    else $error("mask changed without a write");

  // ==========================================================
  // interrupt gating and sticky status
  a_sec_diff_allowed: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (status_q[SEC_DIFF_BIT] && mask_q[SEC_DIFF_BIT]) |=> IRQ)
    else $error("enabled secondary differential input gave no interrupt");

  a_pri_diff_blocked: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (status_q == 8'h10 && !mask_q[PRI_DIFF_BIT]) |=> !IRQ)
    else $error("masked primary differential input interrupted");

  a_se_allowed: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    ((status_q[PRI_SE_BIT] && mask_q[PRI_SE_BIT])
     || (status_q[SEC_SE_BIT] && mask_q[SEC_SE_BIT])) |=> IRQ)
    else $error("enabled single-ended input gave no interrupt");

  a_none_pending_quiet: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    ((status_q & mask_q) == 8'h00) |=> !IRQ)
    else $error("interrupt with no enabled status bit");

  a_status_w1c: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_status && WDATA[PRI_SE_BIT] && !evt.rise[0])
    |=> !status_q[PRI_SE_BIT])
    else $error("status bit not cleared by writing one");

  a_status_sticky: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (status_q[PRI_DIFF_BIT] && !wr_status) |=> status_q[PRI_DIFF_BIT])
    else $error("status bit dropped without a clear");

  // ==========================================================
  // range result on either side of the bound
  a_range_inside: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (!TRACK_OFFSET[OFFSET_W-1]
     && TRACK_OFFSET <= $signed({1'b0, PULL_IN_RANGE_LIMIT}))
    |=> OFFSET_IN_RANGE)
    else $error("offset within limit judged out of range");

  a_range_below: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (TRACK_OFFSET[OFFSET_W-1]
     && (-TRACK_OFFSET) > {1'b0, PULL_IN_RANGE_LIMIT})
    |=> !OFFSET_IN_RANGE)
    else $error("offset below negative limit judged in range");

endmodule

`default_nettype wire

/* File: plim_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module plim_regs_bench
  import plim_pkg::*;
;
  // ==========================================================
  // design hookup
  logic clock;
  logic rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic [NUM_SRC-1:0] src_alarm;
  logic signed [OFFSET_W-1:0] track_offset;
  logic [LIMIT_W-1:0] limit;
  logic in_range;
  logic irq;
  logic [DATA_W-1:0] rv;
  int num_errors;
  int cmp_count;

  plim_regs u_plim_regs (
    .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SRC_ALARM(src_alarm),
    .TRACK_OFFSET(track_offset), .PULL_IN_RANGE_LIMIT(limit),
    .OFFSET_IN_RANGE(in_range), .IRQ(irq)
  );

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ==========================================================
  // access and compare tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // data sampled in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // offset applied one edge, result seen the next
  task automatic range_chk(input int v, input logic exp);
    @(posedge clock);
    track_offset <= OFFSET_W'(v);
    @(posedge clock);
    #1 chk({15'h0000, in_range}, {15'h0000, exp});
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    give_verdict();
  end

  // ==========================================================
  // test sequence
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    src_alarm = 4'h0;
    track_offset = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // reset values and limit assembly
    #1 chk({6'h00, limit}, 16'h0076);
    rd_chk(OFF_FREQ_LIMIT_LOW, 8'h76);
    rd_chk(OFF_FREQ_LIMIT_HIGH, 8'h00);
    rd_chk(OFF_IRQ_MASK_LOW, 8'h00);
    // unused bits and limit concatenation, one idle cycle between writes
    wr_reg(OFF_FREQ_LIMIT_HIGH, 8'hff);
    wr_reg(OFF_FREQ_LIMIT_LOW, 8'ha5);
    rd_chk(OFF_FREQ_LIMIT_HIGH, 8'h03);
    rd_chk(OFF_FREQ_LIMIT_LOW, 8'ha5);
    chk({6'h00, limit}, 16'h03a5);
    wr_reg(OFF_IRQ_MASK_LOW, 8'hff);
    rd_chk(OFF_IRQ_MASK_LOW, 8'h3c);
    rd_chk(8'h50, 8'h00);
    // symmetric bound around limit 933
    range_chk(-933, 1'b1);
    range_chk(-934, 1'b0);
    range_chk(933, 1'b1);
    range_chk(934, 1'b0);
    range_chk(0, 1'b1);
    // each source: blocked while masked, passes once enabled
    for (int i = 0; i < NUM_SRC; i++) begin
      wr_reg(OFF_IRQ_MASK_LOW, 8'h3c ^ (8'h04 << i));
      @(posedge clock);
      src_alarm <= 4'h1 << i;
      repeat (8) @(posedge clock);
      #1 chk({15'h0000, irq}, 16'h0000);
      rd_chk(OFF_IRQ_STATUS_LOW, 8'h04 << i);
      wr_reg(OFF_IRQ_MASK_LOW, 8'h04 << i);
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, irq}, 16'h0001);
      // pin released on a clock edge, like every other input
      @(posedge clock);
      src_alarm <= 4'h0;
      wr_reg(OFF_IRQ_MASK_LOW, 8'h00);
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, irq}, 16'h0000);
      wr_reg(OFF_IRQ_STATUS_LOW, 8'h04 << i);
      rd_chk(OFF_IRQ_STATUS_LOW, 8'h00);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
